// [pfl_asserts.sv]
`timescale 1ns/1ps
module pfl_asserts (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic ser_clk,
  input wire logic latch_enable_strobe,
  input wire logic chip_enable,
  input wire logic [23:0] function_control_latch_q,
  input wire logic powered_down_q,
  input wire logic pump_highz_q,
  input wire logic lock_detect_reset_q,
  input wire logic counter_load_q,
  input wire logic detector_polarity_q,
  input wire logic [1:0] prescale_sel_q,
  input wire logic [2:0] pump_current_q,
  input wire logic pump_gain_bit_q
);
  logic [23:0] f;
  logic [23:0] f_q;
  logic st;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  assign f = function_control_latch_q;
  // decoded outputs lag the latch, so judge them only once it held
  assign st = f == f_q;
  always_ff @(posedge sys_clk) f_q <= f;
  //////////////////////////////////////////////////////////////////
  property p_le; $rose(latch_enable_strobe) |-> latch_enable_strobe[*4]; endproperty
  a_le: assert property (p_le) else $error("short strobe");
  property p_lc; $rose(latch_enable_strobe) |-> !ser_clk; endproperty
  a_lc: assert property (p_lc) else $error("clock high at strobe");
  property p_ce; !chip_enable[*3] |-> ##[0:4] powered_down_q; endproperty
  a_ce: assert property (p_ce) else $error("pin low but running");
  property p_ap; chip_enable && st && f[3] && !f[21] |-> ##[0:6] powered_down_q; endproperty
  a_ap: assert property (p_ap) else $error("async power-down missing");
  property p_up; chip_enable[*8] ##0 (st && !f[3]) |-> ##[0:4] !powered_down_q; endproperty
  a_up: assert property (p_up) else $error("powered down without cause");
  property p_hz; (powered_down_q && $past(powered_down_q)) || (st && f[8]) |-> pump_highz_q;
  endproperty
  a_hz: assert property (p_hz) else $error("pump not high-z");
  property p_dc; st |-> detector_polarity_q == f[7] && prescale_sel_q == f[23:22]; endproperty
  a_dc: assert property (p_dc) else $error("decode mismatch");
  property p_cu; st && $stable(pump_gain_bit_q) |->
    pump_current_q == ((f[9] && pump_gain_bit_q) ? f[20:18] : f[17:15]); endproperty
  a_cu: assert property (p_cu) else $error("pump current mismatch");
  property p_ld; $rose(powered_down_q) |-> lock_detect_reset_q || $past(lock_detect_reset_q);
  endproperty
  a_ld: assert property (p_ld) else $error("lock detect not reset");
  property p_cl; $rose(powered_down_q) |-> ##[0:1] counter_load_q; endproperty
  a_cl: assert property (p_cl) else $error("counters not loaded");
  property p_ir; $changed(f) && f[1:0] == 2'h3 |-> counter_load_q; endproperty
  a_ir: assert property (p_ir) else $error("init word gave no counter reset");
endmodule // pfl_asserts

// [pfl_device.sv]
`timescale 1ns/1ps
// Functional notes
// - select bits 10 load function latch
// - bit 2 holds counters reset
// - power-down bits act only with enable
// - enable pin low powers down immediately
// - pd1 only: power down right after latch
// - both pd bits: wait next pump event (an init word also triggers it)
// - power-down loads counters to load state
// - power-down makes pump high impedance
// - power-down resets lock detect
// - serial register works while powered down
// - bits 6-4 select output mux
// - fastlock only when bit 9 set
// - bit 10 selects manual or timer exit
// - gain bit 1 uses second current
// - manual mode exits on gain write 0
// - timer mode clears gain on timeout
// - timeout code bits 14-11, timer mode only
// - static current 17-15, fast 20-18
// - prescaler from bits 23-22
// - host keeps prescaler output in range
// - bit 7 sets detector polarity
// - bit 8 three-states pump output
// - 24 bits on rising edge, strobe loads
// - select 11 loads function plus reset
module pfl_device (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  pfl_if.dev link,
  input wire logic chip_enable,
  input wire logic pump_event,
  input wire logic [7:0] mux_sources,
  output logic [23:0] function_control_latch_q,
  output logic counter_hold_reset_q,
  output logic counter_load_q,
  output logic powered_down_q,
  output logic lock_detect_reset_q,
  output logic pump_highz_q,
  output logic multiplexed_output_pin_q,
  output logic detector_polarity_q,
  output logic [1:0] prescale_sel_q,
  output logic [2:0] pump_current_q,
  output logic pump_gain_bit_q
);
  ////////////////////////////////////////////////////////////////
  logic [2:0] sclk_s, le_s, ce_s;
  logic [1:0] dat_s;
  logic [23:0] shift_q;
  logic [5:0] tmr_q;
  logic sync_pd_q, pd_d;
  logic sclk_rise, le_rise;
  assign sclk_rise = sclk_s[1] & ~sclk_s[2];
  assign le_rise = le_s[1] & ~le_s[2];

  // clock and strobe pass two flops before logic, enable three; the third clock and strobe flops find edges
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) sclk_s <= 3'h0;
    else if (clk_en) sclk_s <= {sclk_s[1:0], link.ser_clk};
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) le_s <= 3'h0;
    else if (clk_en) le_s <= {le_s[1:0], link.latch_enable_strobe};
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) ce_s <= 3'h0;
    else if (clk_en) ce_s <= {ce_s[1:0], chip_enable};
  end

  // data lines up with the second clock flop, so it is settled at the edge
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) dat_s <= 2'h0;
    else if (clk_en) dat_s <= {dat_s[0], link.ser_data};
  end

  ////////////////////////////////////////////////////////////////
  // shifter never gated by power-down
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) shift_q <= 24'h000000;
    else if (clk_en && sclk_rise) shift_q <= {shift_q[22:0], dat_s[1]};
  end

  logic [1:0] sel;
  logic func_wr, init_wr, ab_wr;
  assign sel = shift_q[1:0];
  assign func_wr = le_rise && (sel == pfl_pkg::SEL_FUNC || sel == pfl_pkg::SEL_INIT);
  assign init_wr = le_rise && sel == pfl_pkg::SEL_INIT;
  assign ab_wr = le_rise && sel == pfl_pkg::SEL_ABCNT;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) function_control_latch_q <= pfl_pkg::FUNC_RESET;
    else if (clk_en && func_wr) function_control_latch_q <= shift_q;
  end

  logic [23:0] f;
  logic fl_en, fl_mode, pd1, pd2, ce;
  assign f = function_control_latch_q;
  assign fl_en = f[pfl_pkg::POS_FL_EN];
  assign fl_mode = f[pfl_pkg::POS_FL_MODE];
  assign pd1 = f[pfl_pkg::POS_PD1];
  assign pd2 = f[pfl_pkg::POS_PD2];
  assign ce = ce_s[2];

  ////////////////////////////////////////////////////////////////
  // named fields keep every bit position in one place
  logic [2:0] mux_sel, cur_static, cur_fast;
  logic [1:0] presc;
  logic pol_bit, highz_bit, hold_bit;
  assign mux_sel = f[pfl_pkg::POS_MUX_LO +: 3];
  assign cur_static = f[pfl_pkg::POS_CUR1_LO +: 3];
  assign cur_fast = f[pfl_pkg::POS_CUR2_LO +: 3];
  assign presc = f[pfl_pkg::POS_PRE_LO +: 2];
  assign pol_bit = f[pfl_pkg::POS_POL];
  assign highz_bit = f[pfl_pkg::POS_HIGHZ];
  assign hold_bit = f[pfl_pkg::POS_CNT_RESET];

  ////////////////////////////////////////////////////////////////
  // synchronous power-down armed until next pump event or init word
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) sync_pd_q <= 1'b0;
    else if (clk_en) begin
      if (!(ce && pd1 && pd2)) sync_pd_q <= 1'b0;
      else if (pump_event || init_wr) sync_pd_q <= 1'b1;
    end
  end

  always_comb begin
    pd_d = 1'b0;
    if (!ce) pd_d = 1'b1;
    else if (pd1 && !pd2) pd_d = 1'b1;
    else if (pd1 && pd2) pd_d = sync_pd_q;
  end

  // every power-down effect comes from pd_d, so they all move together
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) powered_down_q <= 1'b1;
    else if (clk_en) powered_down_q <= pd_d;
  end

  // an init word also pulses it, like an internal counter reset
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) counter_load_q <= 1'b1;
    else if (clk_en) counter_load_q <= pd_d | init_wr;
  end

  // one-cycle pulse on entry only
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) lock_detect_reset_q <= 1'b1;
    else if (clk_en) lock_detect_reset_q <= pd_d & ~powered_down_q;
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) counter_hold_reset_q <= 1'b0;
    else if (clk_en) counter_hold_reset_q <= hold_bit;
  end

  // held counters also float the pump, so it cannot kick the loop
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) pump_highz_q <= 1'b1;
    else if (clk_en) pump_highz_q <= pd_d | highz_bit | hold_bit;
  end

  ////////////////////////////////////////////////////////////////
  // gain bit: written by host via ab word, cleared by timer
  logic tmr_done;
  assign tmr_done = fl_en && fl_mode && pump_gain_bit_q && tmr_q == 6'h00 && pump_event;
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) pump_gain_bit_q <= 1'b0;
    else if (clk_en) begin
      if (ab_wr) pump_gain_bit_q <= shift_q[pfl_pkg::POS_GAIN];
      else if (tmr_done) pump_gain_bit_q <= 1'b0;
    end
  end

  // timer counts pump events; held at load state while powered down
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) tmr_q <= 6'h00;
    else if (clk_en) begin
      if (pd_d || ab_wr || !(fl_en && fl_mode))
        tmr_q <= 6'(({2'h0, f[pfl_pkg::POS_TC_LO +: 4]} + 6'h01) * pfl_pkg::TC_UNIT - 1);
      else if (pump_event && tmr_q != 6'h00) tmr_q <= tmr_q - 6'h01;
    end
  end

  ////////////////////////////////////////////////////////////////
  // decoded controls are flops, so they lag the latch by one clock
  // fast current only while fastlock is enabled and the gain bit is set
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) pump_current_q <= 3'h0;
    else if (clk_en && fl_en && pump_gain_bit_q) pump_current_q <= cur_fast;
    else if (clk_en) pump_current_q <= cur_static;
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) multiplexed_output_pin_q <= 1'b0;
    else if (clk_en) multiplexed_output_pin_q <= mux_sources[mux_sel];
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) detector_polarity_q <= 1'b0;
    else if (clk_en) detector_polarity_q <= pol_bit;
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) prescale_sel_q <= 2'h0;
    else if (clk_en) prescale_sel_q <= presc;
  end
endmodule // pfl_device

// [pfl_host.sv]
`timescale 1ns/1ps
// host: AXI4-Lite slave; data write starts a 24-bit shift, then strobe
module pfl_host (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  pfl_if.host link,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_SHIFT = 2'b01, ST_STROBE = 2'b10} pfl_st_e;
  pfl_st_e st_q;
  logic [23:0] word_q;
  logic [4:0] bit_q;
  logic [1:0] div_q;
  logic sclk_q, sdat_q, le_q, aw_q, w_q;
  logic [3:0] awa_q;
  logic [31:0] wd_q;
  logic [31:0] sent_q;
  logic busy;
  assign busy = st_q != ST_IDLE;
  assign link.ser_clk = sclk_q;
  assign link.ser_data = sdat_q;
  assign link.latch_enable_strobe = le_q;

  ////////////////////////////////////////////////////////////////
  logic wr_go;
  assign wr_go = aw_q && w_q && !s_axi_bvalid;
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awa_q <= 4'h0;
      wd_q <= 32'h00000000;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else if (clk_en) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q <= 1'b1;
        awa_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q <= 1'b1;
        wd_q <= s_axi_wdata;
      end
      if (wr_go) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // data write while busy is refused with slverr
        s_axi_bresp <= (awa_q == pfl_pkg::ADDR_DATA && !busy) ? 2'h0 : 2'h2;
      end else if (s_axi_bready) s_axi_bvalid <= 1'b0;
    end
  end
  assign s_axi_awready = !aw_q;
  assign s_axi_wready = !w_q;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
    end else if (clk_en) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        case (s_axi_araddr)
          pfl_pkg::ADDR_DATA: s_axi_rdata <= sent_q;
          pfl_pkg::ADDR_STAT: s_axi_rdata <= {31'h0, busy};
          default: s_axi_rdata <= 32'h00000000;
        endcase
      end else if (s_axi_rready) s_axi_rvalid <= 1'b0;
    end
  end
  assign s_axi_arready = !s_axi_rvalid;
  assign s_axi_rresp = 2'h0;

  ////////////////////////////////////////////////////////////////
  // msb first; data set on falling edge, device samples rising
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= ST_IDLE;
      word_q <= 24'h000000;
      sent_q <= 32'h00000000;
      bit_q <= 5'h00;
      div_q <= 2'h0;
      sclk_q <= 1'b0;
      sdat_q <= 1'b0;
      le_q <= 1'b0;
    end else if (clk_en) begin
      div_q <= div_q + 2'h1;
      case (st_q)
        ST_IDLE: begin
          le_q <= 1'b0;
          if (wr_go && awa_q == pfl_pkg::ADDR_DATA) begin
            word_q <= wd_q[23:0];
            sent_q <= {8'h00, wd_q[23:0]};
            bit_q <= 5'h17;
            div_q <= 2'h0;
            st_q <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (div_q == 2'h0) begin
            sclk_q <= 1'b0;
            sdat_q <= word_q[bit_q];
          end else if (div_q == 2'h2) begin
            sclk_q <= 1'b1;
            if (bit_q == 5'h00) begin
              // restart the divider so the strobe stands four clocks
              div_q <= 2'h0;
              st_q <= ST_STROBE;
            end else begin
              bit_q <= bit_q - 5'h01;
            end
          end
        end
        ST_STROBE: begin
          sclk_q <= 1'b0;
          le_q <= 1'b1;
          if (div_q == 2'h3) st_q <= ST_IDLE;
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end
endmodule // pfl_host

// [pfl_if.sv]
`timescale 1ns/1ps
interface pfl_if;
  logic ser_clk;
  logic ser_data;
  logic latch_enable_strobe;
  modport host (output ser_clk, output ser_data, output latch_enable_strobe);
  modport dev (input ser_clk, input ser_data, input latch_enable_strobe);
endinterface // pfl_if

// [pfl_pkg.sv]
package pfl_pkg;
  localparam int WORD_BITS = 24;
  // control bits and field positions of the 24-bit word
  localparam logic [1:0] SEL_RCNT = 2'h0;
  localparam logic [1:0] SEL_ABCNT = 2'h1;
  localparam logic [1:0] SEL_FUNC = 2'h2;
  localparam logic [1:0] SEL_INIT = 2'h3;
  localparam int POS_CNT_RESET = 2;
  localparam int POS_PD1 = 3;
  localparam int POS_MUX_LO = 4;
  localparam int POS_POL = 7;
  localparam int POS_HIGHZ = 8;
  localparam int POS_FL_EN = 9;
  localparam int POS_FL_MODE = 10;
  localparam int POS_TC_LO = 11;
  localparam int POS_CUR1_LO = 15;
  localparam int POS_CUR2_LO = 18;
  localparam int POS_PD2 = 21;
  localparam int POS_PRE_LO = 22;
  localparam int POS_GAIN = 21;
  localparam logic [23:0] FUNC_RESET = 24'h000002;
  // timeout in pfd events: (code+1)*4
  localparam int TC_UNIT = 4;
  // host register map (byte addresses)
  localparam logic [3:0] ADDR_DATA = 4'h0;
  localparam logic [3:0] ADDR_CTRL = 4'h4;
  localparam logic [3:0] ADDR_STAT = 4'h8;
  localparam int LINK_DIV = 4;
endpackage

// [testbench.sv]
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin failures++; \
  $display("ERROR t=%0t got %0h exp %0h", $time, a, e); end end
module testbench;
  logic sys_clk = 0, sys_rst = 1, chip_enable = 0, pump_event = 0;
  logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, counter_hold_reset_q, counter_load_q, powered_down_q;
  logic lock_detect_reset_q, pump_highz_q, detector_polarity_q, pump_gain_bit_q;
  logic [1:0] s_axi_bresp, s_axi_rresp, prescale_sel_q, r;
  logic [2:0] pump_current_q;
  logic [23:0] function_control_latch_q;
  int failures = 0, n_checks = 0;
  // prescaler code 01 keeps the prescaler output in range
  localparam logic [23:0] W1 = 24'h5580A2;
  localparam logic [7:0] MUX_SRC = 8'h5A;
  logic mux_pin;
  pfl_if lk();
  pfl_host i_pfl_host (.*, .clk_en(1'b1), .link(lk), .s_axi_wstrb(4'hF));
  pfl_device i_pfl_device (.*, .clk_en(1'b1), .link(lk), .mux_sources(MUX_SRC),
    .multiplexed_output_pin_q(mux_pin));
  pfl_asserts i_pfl_asserts (.*, .ser_clk(lk.ser_clk),
    .latch_enable_strobe(lk.latch_enable_strobe));
  initial forever #10 sys_clk = ~sys_clk;
  //////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ready is sampled mid-cycle, where it cannot race the edge
  task automatic wr(input logic [3:0] a, input logic [31:0] w);
    logic ha, hw, hb;
    @(posedge sys_clk);
    {s_axi_awaddr, s_axi_wdata} <= {a, w};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    forever begin
      @(negedge sys_clk);
      {ha, hw, hb} = {s_axi_awvalid & s_axi_awready, s_axi_wvalid & s_axi_wready, s_axi_bvalid};
      r = s_axi_bresp;
      @(posedge sys_clk);
      if (ha) s_axi_awvalid <= 0;
      if (hw) s_axi_wvalid <= 0;
      if (hb) begin
        s_axi_bready <= 0;
        break;
      end
    end
  endtask
  task automatic rd(input logic [3:0] a);
    logic ha, hr;
    @(posedge sys_clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    forever begin
      @(negedge sys_clk);
      {ha, hr, d} = {s_axi_arvalid & s_axi_arready, s_axi_rvalid, s_axi_rdata};
      @(posedge sys_clk);
      if (ha) s_axi_arvalid <= 0;
      if (hr) begin
        s_axi_rready <= 0;
        break;
      end
    end
  endtask
  task automatic send(input logic [23:0] w);
    wr(pfl_pkg::ADDR_DATA, {8'h00, w});
    `CHK(r, 2'h0)
    rd(pfl_pkg::ADDR_STAT);
    for (int i = 0; i < 300 && d[0] !== 1'b0; i++) rd(pfl_pkg::ADDR_STAT);
    `CHK(d[0], 1'b0)
    repeat (8) @(posedge sys_clk);
  endtask
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge sys_clk) pump_event <= 1;
      @(posedge sys_clk) pump_event <= 0;
    end
    repeat (4) @(posedge sys_clk);
  endtask
  //////////////////////////////////////////////////////////////////
  task automatic t_func;
    `CHK(function_control_latch_q, pfl_pkg::FUNC_RESET)
    `CHK(powered_down_q, 1'b1)
    @(posedge sys_clk) chip_enable <= 1;
    send(W1);
    `CHK({prescale_sel_q, detector_polarity_q, pump_current_q}, 6'h1B)
    `CHK(mux_pin, MUX_SRC[2])
    `CHK({pump_highz_q, powered_down_q}, 2'h0)
    send(24'h0ABC00);
    `CHK(function_control_latch_q, W1)
    send(W1 | 24'h000104);
    `CHK({counter_hold_reset_q, pump_highz_q}, 2'h3)
    wr(pfl_pkg::ADDR_CTRL, 32'h0);
    `CHK(r, 2'h2)
    rd(pfl_pkg::ADDR_DATA);
    `CHK(d[23:0], W1 | 24'h000104)
  endtask
  task automatic t_pd;
    send(W1 | 24'h000008);
    `CHK({powered_down_q, pump_highz_q}, 2'h3)
    send(W1);
    send(W1 | 24'h200008);
    `CHK(powered_down_q, 1'b0)
    pulse(1);
    `CHK(powered_down_q, 1'b1)
    send(W1 | 24'h000010);
    `CHK({mux_pin, powered_down_q}, {MUX_SRC[3], 1'b0})
    @(posedge sys_clk) chip_enable <= 0;
    send(W1 | 24'h000200);
    `CHK({powered_down_q, function_control_latch_q}, {1'b1, W1 | 24'h000200})
    @(posedge sys_clk) chip_enable <= 1;
  endtask
  task automatic t_fast;
    send(W1 | 24'h000E00);
    send(24'h200001);
    `CHK({pump_gain_bit_q, pump_current_q}, 4'hD)
    pulse(2 * pfl_pkg::TC_UNIT - 1);
    `CHK(pump_gain_bit_q, 1'b1)
    pulse(1);
    `CHK({pump_gain_bit_q, pump_current_q}, 4'h3)
    send(W1 | 24'h000200);
    send(24'h200001);
    pulse(40);
    `CHK(pump_gain_bit_q, 1'b1)
    send(24'h000001);
    `CHK(pump_gain_bit_q, 1'b0)
    send(W1 | 24'h000003);
    `CHK(function_control_latch_q[23:2], W1[23:2])
  endtask
  initial begin
    repeat (12) @(posedge sys_clk);
    sys_rst <= 0;
    @(posedge sys_clk);
    t_func;
    t_pd;
    t_fast;
    give_verdict;
  end
  initial begin
    #1000000;
    failures++;
    give_verdict;
  end
endmodule // testbench
